// ---- dvs_pkg.sv ----
// Purpose: Shared constants and types for the buck target select and voltage reset block
// Assumes: 25 MHz core clock, four bucks, registers reached over the two-wire serial port
// Notes:   Offsets beside the select control registers sit next to each select register
package dvs_pkg;

  localparam int NBUCK = 4;

  // Select control register offsets, one per buck
  localparam logic [7:0] CTRL_OFS [NBUCK] = '{8'h52, 8'h6C, 8'h86, 8'hA0};
  // Offsets of the companion registers, relative to the select control register
  localparam logic [1:0] SUB_CTRL  = 2'h0;
  localparam logic [1:0] SUB_TGT0  = 2'h1;
  localparam logic [1:0] SUB_TGT1  = 2'h2;
  localparam logic [1:0] SUB_SCALE = 2'h3;

  // Select control fields
  localparam int         SEL_MODE_LSB = 0;
  localparam int         SEL_POL_BIT  = 2;
  localparam logic [1:0] MODE_PIN     = 2'h2;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] TGT0_RST  = 8'h3C;
  localparam logic [7:0] TGT1_RST  = 8'h50;
  localparam logic [7:0] SCALE_RST = 8'h01;

  // Serial device address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;

  // Voltage reset debounce
  localparam int          CLK_MHZ          = 25;
  localparam int          VRST_DEBOUNCE_US = 100;
  localparam logic [11:0] VRST_CYC         = 12'(VRST_DEBOUNCE_US * CLK_MHZ);

  // Serial port states
  typedef enum logic [3:0] {
    DVS_IDLE  = 4'b0000,
    DVS_ADDR  = 4'b0001,
    DVS_AACK  = 4'b0010,
    DVS_PTR   = 4'b0011,
    DVS_PACK  = 4'b0100,
    DVS_WDATA = 4'b0101,
    DVS_WACK  = 4'b0110,
    DVS_RDATA = 4'b0111,
    DVS_RACK  = 4'b1000
  } dvs_st_e;

endpackage

// ---- dvs_buck_if.sv ----
// Purpose: Per-buck bundle between the register core and a target selector
// Assumes: One instance per buck
// Notes:   Register core drives settings, selector returns choice and output code
`timescale 1ns/1ns
interface dvs_buck_if;
  logic [1:0] mode;
  logic       pol;
  logic       pin;
  logic [7:0] tgt0;
  logic [7:0] tgt1;
  logic       sel;
  logic [7:0] vout;

  modport core (output mode, output pol, output pin, output tgt0, output tgt1,
                input sel, input vout);
  modport pick (input mode, input pol, input pin, input tgt0, input tgt1,
                output sel, output vout);
endinterface

// ---- dvs_target_sel.sv ----
// Purpose: Chooses one buck's voltage target and holds its output voltage code
// Assumes: Pin input is already synchronised
// Notes:   Modes other than pin mode keep target zero
`timescale 1ns/1ns
module dvs_target_sel
  import dvs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Settings and result
  dvs_buck_if.pick b
);

  logic       sel_q;
  logic       sel_d;
  logic [7:0] vout_q;
  logic [7:0] vout_d;

  // Target choice; undefined modes fall back to target zero for safety
  always_comb begin
    sel_d  = (b.mode == MODE_PIN) && (b.pin == b.pol);
    vout_d = sel_d ? b.tgt1 : b.tgt0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_q  <= 1'b0;
      vout_q <= TGT0_RST;
    end else begin
      sel_q  <= sel_d;
      vout_q <= vout_d;
    end
  end

  assign b.sel  = sel_q;
  assign b.vout = vout_q;

  property p_pin_mode;
    @(posedge core_clk) disable iff (rst)
      (b.mode == MODE_PIN) ##0 (b.pin == b.pol) |=> sel_q && (vout_q == $past(b.tgt1));
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin mode target one missed");

  property p_fixed_zero;
    @(posedge core_clk) disable iff (rst)
      (b.mode != MODE_PIN) |=> !sel_q && (vout_q == $past(b.tgt0));
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("fixed mode not target zero");

endmodule

// ---- dvs_select_top.sv ----
// Purpose: Target select registers, serial register port, voltage reset and enable
// Assumes: Serial port up to 400 kHz; all pins asynchronous to core_clk
// Notes:   Master enable low holds every register at its reset value
`timescale 1ns/1ns
module dvs_select_top
  import dvs_pkg::*;
(
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Serial register port
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe,
  // Control pins
  input  wire logic                        target_pin_one,
  input  wire logic                        target_pin_two,
  input  wire logic                        target_pin_three,
  input  wire logic                        target_pin_four,
  input  wire logic                        voltage_reset_pin_n,
  input  wire logic                        master_en_pin,
  // Converter side
  output logic                             device_enable,
  output logic                             restore_active,
  output logic [dvs_pkg::NBUCK-1:0]        buck_target_sel,
  output logic [dvs_pkg::NBUCK-1:0]        buck_scale_en,
  output logic [dvs_pkg::NBUCK-1:0][7:0]   buck_vout
);
  import dvs_pkg::*;

  localparam int PIN_N = 8;

  // Synchroniser and filter state
  logic [PIN_N-1:0] s1_q, s2_q, s3_q, f_q, f_d;
  logic             scl_p_q, sda_p_q;
  // Debounce state
  logic [11:0]      vcnt_q, vcnt_d;
  // Serial port state
  dvs_st_e          st_q, st_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [7:0]       sh_q, sh_d;
  logic [7:0]       ptr_q, ptr_d;
  logic             rw_q, rw_d;
  logic             drv_q, drv_d;
  logic             wr_en;
  logic [7:0]       rd_byte;
  // Register file
  logic [7:0]       ctrl_q [NBUCK];
  logic [7:0]       ctrl_d [NBUCK];
  logic [7:0]       t0_q   [NBUCK];
  logic [7:0]       t0_d   [NBUCK];
  logic [7:0]       t1_q   [NBUCK];
  logic [7:0]       t1_d   [NBUCK];
  logic [7:0]       sc_q   [NBUCK];
  logic [7:0]       sc_d   [NBUCK];
  // Decode results
  logic             hit;
  logic [1:0]       hit_bk;
  logic [1:0]       hit_sub;
  // Filtered levels
  logic             scl_f, sda_f, vrst_f, en_f;
  logic [NBUCK-1:0] pin_f;
  logic             scl_rise, scl_fall, start_c, stop_c;

  assign scl_f  = f_q[0];
  assign sda_f  = f_q[1];
  assign pin_f  = f_q[5:2];
  assign vrst_f = f_q[6];
  assign en_f   = f_q[7];

  // Three-stage sync; a level counts only once stages two and three agree
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q    <= 8'hC3;
      s2_q    <= 8'hC3;
      s3_q    <= 8'hC3;
      f_q     <= 8'h43;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      s1_q    <= {master_en_pin, voltage_reset_pin_n, target_pin_four, target_pin_three,
                  target_pin_two, target_pin_one, sda_in, scl_in};
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      f_q     <= f_d;
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // Voltage reset debounce; releases at once so a short glitch never restores
  always_comb begin
    if (vrst_f || !en_f) begin
      vcnt_d = 12'h000;
    end else if (vcnt_q != VRST_CYC) begin
      vcnt_d = vcnt_q + 12'h001;
    end else begin
      vcnt_d = vcnt_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      vcnt_q <= 12'h000;
    end else begin
      vcnt_q <= vcnt_d;
    end
  end

  assign restore_active = (vcnt_q == VRST_CYC);

  // Address decode over the four select groups
  always_comb begin
    hit     = 1'b0;
    hit_bk  = 2'h0;
    hit_sub = 2'h0;
    for (int i = 0; i < NBUCK; i++) begin
      if (ptr_q[7:2] == CTRL_OFS[i][7:2] && ptr_q[1:0] >= CTRL_OFS[i][1:0] &&
          ptr_q[1:0] == CTRL_OFS[i][1:0]) begin
        hit     = 1'b1;
        hit_bk  = 2'(i);
        hit_sub = SUB_CTRL;
      end else if (ptr_q - CTRL_OFS[i] < 8'h04 && ptr_q > CTRL_OFS[i]) begin
        hit     = 1'b1;
        hit_bk  = 2'(i);
        hit_sub = 2'(ptr_q - CTRL_OFS[i]);
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit) begin
      case (hit_sub)
        SUB_CTRL:  rd_byte = ctrl_q[hit_bk];
        SUB_TGT0:  rd_byte = t0_q[hit_bk];
        SUB_TGT1:  rd_byte = t1_q[hit_bk];
        default:   rd_byte = sc_q[hit_bk];
      endcase
    end
  end

  assign scl_rise = scl_f && !scl_p_q;
  assign scl_fall = !scl_f && scl_p_q;
  assign start_c  = scl_f && scl_p_q && sda_p_q && !sda_f;
  assign stop_c   = scl_f && scl_p_q && !sda_p_q && sda_f;

  // Serial port: address, pointer, then data bytes with auto-increment
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    rw_d  = rw_q;
    drv_d = drv_q;
    wr_en = 1'b0;
    if (!en_f) begin
      st_d  = DVS_IDLE;
      drv_d = 1'b0;
    end else if (start_c) begin
      st_d  = DVS_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_c) begin
      st_d  = DVS_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        DVS_ADDR, DVS_PTR, DVS_WDATA: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_f};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            drv_d = 1'b1;
            if (st_q == DVS_ADDR) begin
              rw_d = sh_q[0];
              st_d = DVS_AACK;
              if (sh_q[7:1] != DEV_ADDR) begin
                st_d  = DVS_IDLE;
                drv_d = 1'b0;
              end
            end else if (st_q == DVS_PTR) begin
              ptr_d = sh_q;
              st_d  = DVS_PACK;
            end else begin
              wr_en = 1'b1;
              st_d  = DVS_WACK;
            end
          end
        end
        DVS_AACK, DVS_PACK, DVS_WACK: begin
          if (scl_fall) begin
            drv_d = 1'b0;
            st_d  = DVS_WDATA;
            if (st_q == DVS_AACK && rw_q) begin
              st_d  = DVS_RDATA;
              sh_d  = rd_byte;
              drv_d = !rd_byte[7];
            end else if (st_q == DVS_AACK) begin
              st_d = DVS_PTR;
            end else if (st_q == DVS_WACK) begin
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        DVS_RDATA: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            st_d  = DVS_RACK;
            cnt_d = 4'h0;
            drv_d = 1'b0;
            ptr_d = ptr_q + 8'h01;
          end else if (scl_fall) begin
            sh_d  = {sh_q[6:0], 1'b0};
            drv_d = !sh_q[6];
          end
        end
        DVS_RACK: begin
          if (scl_rise && sda_f) begin
            st_d = DVS_IDLE; // Master refused more data
          end else if (scl_fall) begin
            st_d  = DVS_RDATA;
            sh_d  = rd_byte;
            drv_d = !rd_byte[7];
          end
        end
        default: st_d = DVS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q  <= DVS_IDLE;
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
      ptr_q <= 8'h00;
      rw_q  <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      ptr_q <= ptr_d;
      rw_q  <= rw_d;
      drv_q <= drv_d;
    end
  end

  // Open-drain data line only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = drv_q;

  // Register file; the reset pin wins over a write to the same register
  always_comb begin
    for (int i = 0; i < NBUCK; i++) begin
      ctrl_d[i] = ctrl_q[i];
      t0_d[i]   = t0_q[i];
      t1_d[i]   = t1_q[i];
      sc_d[i]   = sc_q[i];
      if (wr_en && hit && hit_bk == 2'(i)) begin
        case (hit_sub)
          SUB_CTRL: ctrl_d[i] = sh_q;
          SUB_TGT0: t0_d[i]   = sh_q;
          SUB_TGT1: t1_d[i]   = sh_q;
          default:  sc_d[i]   = sh_q;
        endcase
      end
      if (restore_active) begin
        t0_d[i] = TGT0_RST;
        t1_d[i] = TGT1_RST;
        sc_d[i] = SCALE_RST;
      end
      if (!en_f) begin
        ctrl_d[i] = CTRL_RST;
        t0_d[i]   = TGT0_RST;
        t1_d[i]   = TGT1_RST;
        sc_d[i]   = SCALE_RST;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NBUCK; i++) begin
      if (rst) begin
        ctrl_q[i] <= CTRL_RST;
        t0_q[i]   <= TGT0_RST;
        t1_q[i]   <= TGT1_RST;
        sc_q[i]   <= SCALE_RST;
      end else begin
        ctrl_q[i] <= ctrl_d[i];
        t0_q[i]   <= t0_d[i];
        t1_q[i]   <= t1_d[i];
        sc_q[i]   <= sc_d[i];
      end
    end
  end

  // One selector per buck
  dvs_buck_if bi [NBUCK] ();

  for (genvar g = 0; g < NBUCK; g++) begin : g_buck
    assign bi[g].mode = ctrl_q[g][SEL_MODE_LSB +: 2];
    assign bi[g].pol  = ctrl_q[g][SEL_POL_BIT];
    assign bi[g].pin  = pin_f[g];
    assign bi[g].tgt0 = t0_q[g];
    assign bi[g].tgt1 = t1_q[g];
    assign buck_target_sel[g] = bi[g].sel;
    assign buck_vout[g]       = bi[g].vout;
    assign buck_scale_en[g]   = sc_q[g][0];
    dvs_target_sel u_sel (
      .core_clk (core_clk),
      .rst      (rst),
      .b        (bi[g])
    );
  end

  assign device_enable = en_f;

  property p_restore_after_wait;
    @(posedge core_clk) disable iff (rst)
      (vcnt_q == VRST_CYC - 12'h001) && !vrst_f && en_f |=> restore_active;
  endproperty
  a_restore_after_wait: assert property (p_restore_after_wait) else $error("restore late");

  property p_no_early_restore;
    @(posedge core_clk) disable iff (rst)
      $rose(restore_active) |-> $past(!vrst_f) && $past(vcnt_q) == VRST_CYC - 12'h001;
  endproperty
  a_no_early_restore: assert property (p_no_early_restore) else $error("restore early");

  property p_restore_vals;
    @(posedge core_clk) disable iff (rst)
      restore_active |=> t0_q[0] == TGT0_RST && t1_q[3] == TGT1_RST && sc_q[2] == SCALE_RST;
  endproperty
  a_restore_vals: assert property (p_restore_vals) else $error("restore values wrong");

  property p_shutdown;
    @(posedge core_clk) disable iff (rst)
      !en_f |-> !device_enable ##1 (ctrl_q[1] == CTRL_RST && st_q == DVS_IDLE);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not forced");

  property p_sync_agree;
    @(posedge core_clk) disable iff (rst)
      $changed(f_q[2]) |-> $past(s3_q[2]) == $past(s2_q[2]);
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("pin used unsynchronised");

  property p_wr_b2;
    @(posedge core_clk) disable iff (rst || !en_f)
      wr_en && ptr_q == CTRL_OFS[1] |=> ctrl_q[1] == $past(sh_q);
  endproperty
  a_wr_b2: assert property (p_wr_b2) else $error("buck two select write lost");

  property p_wr_b3;
    @(posedge core_clk) disable iff (rst || !en_f)
      wr_en && ptr_q == CTRL_OFS[2] |=> ctrl_q[2] == $past(sh_q);
  endproperty
  a_wr_b3: assert property (p_wr_b3) else $error("buck three select write lost");

  property p_wr_b4;
    @(posedge core_clk) disable iff (rst || !en_f)
      wr_en && ptr_q == CTRL_OFS[3] |=> ctrl_q[3] == $past(sh_q);
  endproperty
  a_wr_b4: assert property (p_wr_b4) else $error("buck four select write lost");

endmodule

// ---- dvs_host_model.sv ----
// Purpose: Host stand-in that drives the two-wire register port
// Assumes: Open-drain data line with a pull-up; device pulls low through dev_pull
// Notes:   Each phase lasts 10 core clocks so the device filter always settles
`timescale 1ns/1ns
module dvs_host_model
  import dvs_pkg::*;
(
  // Clock
  input  wire logic core_clk,
  // Wire levels
  output logic      scl,
  output logic      sda,
  input  wire logic dev_pull
);
  logic host_low;

  // Pull-up wins unless either party pulls low
  assign sda = !(host_low || dev_pull);

  // Idle bus at time zero
  initial begin
    scl      = 1'h1;
    host_low = 1'h0;
  end

  // One phase of the serial clock
  task automatic hold();
    repeat (10) @(posedge core_clk);
  endtask

  // Start or repeated start, data falls while clock is high
  task automatic start();
    hold();
    host_low <= 1'h0;
    hold();
    scl      <= 1'h1;
    hold();
    host_low <= 1'h1;
    hold();
    scl      <= 1'h0;
  endtask

  // Stop, data rises while clock is high
  task automatic stop();
    hold();
    host_low <= 1'h1;
    hold();
    scl      <= 1'h1;
    hold();
    host_low <= 1'h0;
    hold();
  endtask

  // Data changes only a full phase after the clock fell, never near an edge
  task automatic bit_io(input logic b, output logic s);
    hold();
    host_low <= !b;
    hold();
    scl      <= 1'h1;
    hold();
    s = sda;
    scl      <= 1'h0;
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic last,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, ack);
  endtask

  // Pointer then data; nak is high if any byte went unacknowledged
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic       k0, k1, k2;
    start();
    byte_io({DEV_ADDR, 1'h0}, 1'h1, q, k0);
    byte_io(a, 1'h1, q, k1);
    byte_io(d, 1'h1, q, k2);
    stop();
    nak = k0 | k1 | k2;
  endtask

  // Pointer, repeated start, one byte closed with a not-acknowledge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start();
    byte_io({DEV_ADDR, 1'h0}, 1'h1, q, k);
    byte_io(a, 1'h1, q, k);
    start();
    byte_io({DEV_ADDR, 1'h1}, 1'h1, q, k);
    byte_io(8'hFF, 1'h1, d, k);
    stop();
  endtask

  // Two bytes in one read; the first is acknowledged so the second comes from the advanced pointer
  task automatic read_pair(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] q;
    logic       k;
    start();
    byte_io({DEV_ADDR, 1'h0}, 1'h1, q, k);
    byte_io(a, 1'h1, q, k);
    start();
    byte_io({DEV_ADDR, 1'h1}, 1'h1, q, k);
    byte_io(8'hFF, 1'h0, d0, k);
    byte_io(8'hFF, 1'h1, d1, k);
    stop();
  endtask
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for target select, voltage reset and enable
// Assumes: Registers reached only through the serial port of the host model
// Notes:   Control pins driven here; expectations come from package defaults
`timescale 1ns/1ns
module tb;
  import dvs_pkg::*;
  logic                  core_clk, rst, scl, sda, sda_out, sda_oe;
  logic [NBUCK-1:0]      tpin, buck_target_sel, buck_scale_en;
  logic                  vrst_n, men, device_enable, restore_active;
  logic [NBUCK-1:0][7:0] buck_vout;
  int                    n_errors, n_tests, cyc;

  dvs_select_top dvs_select_top_i (
    .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .target_pin_one(tpin[0]), .target_pin_two(tpin[1]),
    .target_pin_three(tpin[2]), .target_pin_four(tpin[3]),
    .voltage_reset_pin_n(vrst_n), .master_en_pin(men),
    .device_enable(device_enable), .restore_active(restore_active),
    .buck_target_sel(buck_target_sel), .buck_scale_en(buck_scale_en),
    .buck_vout(buck_vout));

  dvs_host_model dvs_host_model_i (
    .core_clk(core_clk), .scl(scl), .sda(sda), .dev_pull(sda_oe && !sda_out));

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  // Hang guard, about 1.75 times the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      $display("[FAIL] timeout expected finish seen hang");
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic nak;
    dvs_host_model_i.write_reg(a, d, nak);
    chk("write ack", 8'h00, {7'h00, nak});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    dvs_host_model_i.read_reg(a, q);
    chk(what, exp, q);
  endtask

  // Bounded wait for the filtered enable
  task automatic wait_en();
    for (int i = 0; i < 20 && device_enable !== 1'h1; i++) @(posedge core_clk);
    chk("device_enable", 8'h01, {7'h00, device_enable});
  endtask

  task automatic t_defaults();
    logic [7:0] d0;
    logic [7:0] d1;
    for (int b = 0; b < NBUCK; b++) begin
      rdchk(CTRL_OFS[b], CTRL_RST, "select ctrl");
      rdchk(CTRL_OFS[b] + {6'h00, SUB_TGT1}, TGT1_RST, "target one");
      chk("vout", TGT0_RST, buck_vout[b]);
      chk("scale_en", 8'h01, {7'h00, buck_scale_en[b]});
    end
    // Acknowledged first byte brings a second byte, read after the pointer stepped from target zero to target one
    dvs_host_model_i.read_pair(CTRL_OFS[2] + {6'h00, SUB_TGT0}, d0, d1);
    chk("pair target zero", TGT0_RST, d0);
    chk("pair target one", TGT1_RST, d1);
    wr(8'h10, 8'hFF);
    rdchk(8'h10, 8'h00, "unmapped read");
    $display("t_defaults done");
  endtask

  // Mode 00 must ignore the pins whatever they do
  task automatic t_pin_ignored();
    for (int v = 0; v < 2; v++) begin
      tpin <= {NBUCK{v[0]}};
      waitc(10);
      chk("sel ignored", 8'h00, {4'h0, buck_target_sel});
    end
    $display("t_pin_ignored done");
  endtask

  // Every mode code and both polarities, one buck at a time
  task automatic t_pin_mode();
    logic [7:0] cv [5] = '{8'h04, 8'h05, 8'h07, 8'h02, 8'h06};
    logic       e;
    for (int b = 0; b < NBUCK; b++) begin
      for (int c = 0; c < 5; c++) begin
        wr(CTRL_OFS[b], cv[c]);
        for (int p = 0; p < 2; p++) begin
          tpin <= {NBUCK{p[0]}};
          waitc(10);
          e = (cv[c][1:0] == MODE_PIN) && (p[0] == cv[c][SEL_POL_BIT]);
          chk("target sel", {4'h0, 4'(e) << b}, {4'h0, buck_target_sel});
          chk("vout pick", e ? TGT1_RST : TGT0_RST, buck_vout[b]);
        end
      end
      wr(CTRL_OFS[b], CTRL_RST);
    end
    $display("t_pin_mode done");
  endtask

  task automatic t_restore();
    logic early;
    int   i;
    early = 1'h0;
    wr(CTRL_OFS[0] + {6'h00, SUB_TGT1}, 8'h20);
    wr(CTRL_OFS[0] + {6'h00, SUB_SCALE}, 8'h00);
    wr(CTRL_OFS[0], {6'h00, MODE_PIN});
    tpin <= '0;
    waitc(10);
    chk("vout written", 8'h20, buck_vout[0]);
    // Short glitch must be filtered out
    vrst_n <= 1'h0;
    for (i = 0; i < 2400; i++) begin
      @(posedge core_clk);
      if (restore_active === 1'h1) early = 1'h1;
    end
    vrst_n <= 1'h1;
    chk("early restore", 8'h00, {7'h00, early});
    waitc(8);
    rdchk(CTRL_OFS[0] + {6'h00, SUB_TGT1}, 8'h20, "target kept");
    // Bench holds the pin low past the debounce time
    vrst_n <= 1'h0;
    for (i = 0; i < 2600 && restore_active !== 1'h1; i++) @(posedge core_clk);
    chk("restore delay", 8'h01, {7'h00, i >= 2500 && i <= 2510});
    waitc(4);
    vrst_n <= 1'h1;
    waitc(8);
    chk("restore off", 8'h00, {7'h00, restore_active});
    chk("vout restored", TGT1_RST, buck_vout[0]);
    chk("scale restored", 8'h01, {7'h00, buck_scale_en[0]});
    rdchk(CTRL_OFS[0] + {6'h00, SUB_TGT1}, TGT1_RST, "target restored");
    rdchk(CTRL_OFS[0] + {6'h00, SUB_SCALE}, SCALE_RST, "scale reg");
    rdchk(CTRL_OFS[0], {6'h00, MODE_PIN}, "ctrl kept");
    wr(CTRL_OFS[0], CTRL_RST);
    $display("t_restore done");
  endtask

  task automatic t_enable();
    logic nak;
    wr(CTRL_OFS[1] + {6'h00, SUB_TGT1}, 8'h11);
    men <= 1'h0;
    waitc(8);
    chk("shutdown", 8'h00, {7'h00, device_enable});
    dvs_host_model_i.write_reg(CTRL_OFS[1], 8'h02, nak);
    chk("port idle", 8'h01, {7'h00, nak});
    men <= 1'h1;
    wait_en();
    rdchk(CTRL_OFS[1] + {6'h00, SUB_TGT1}, TGT1_RST, "cleared by shutdown");
    $display("t_enable done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    core_clk = 1'h0;
    rst      = 1'h1;
    tpin     = '0;
    vrst_n   = 1'h1;
    men      = 1'h1;
    n_errors = 0;
    n_tests  = 0;
    waitc(5);
    rst <= 1'h0;
    wait_en();
    t_defaults();
    t_pin_ignored();
    t_pin_mode();
    t_restore();
    t_enable();
    tally_and_finish();
  end
endmodule
